// File: rtl/rgc_defs.svh
/*
 Offsets, field positions, reset values and timing counts of the receiver
 gain control and signal-strength block. Assumes a 10-bit register address
 and a 100 MHz core clock.
*/
`ifndef RGC_DEFS_SVH
`define RGC_DEFS_SVH

`define RGC_OFF_DISC_BW 10'h10f
`define RGC_OFF_DISC_PHASE 10'h112
`define RGC_OFF_LOCK_CFG 10'h113
`define RGC_OFF_DEMOD_CFG 10'h115
`define RGC_OFF_STRENGTH 10'h312
`define RGC_OFF_CONV_LO 10'h327
`define RGC_OFF_CONV_HI 10'h328
`define RGC_OFF_DWELL_DIV 10'h32f
`define RGC_OFF_OVERRIDE 10'h35d
`define RGC_OFF_RAISE_TH 10'h35e
`define RGC_OFF_CUT_TH 10'h35f
`define RGC_OFF_GAIN_STATE 10'h360
`define RGC_OFF_CONV_WORD 10'h361

`define RGC_RST_DWELL_DIV 8'h28
`define RGC_RST_RAISE_TH 8'h20
`define RGC_RST_CUT_TH 8'h60
`define RGC_RST_DISC_BW 8'h10
`define RGC_RST_ZERO 8'h00

`define RGC_OVR_HOLD_BIT 6
`define RGC_DEMOD_CORRELATOR 2'h0

`define RGC_CLK_PERIOD_NS 10
`define RGC_DWELL_TIME_NS 25000
`define RGC_DWELL_DIV_DEFAULT 40

`define RGC_STAGE_MIN 3'h1
`define RGC_STAGE_MAX 3'h6
`define RGC_CODE_S1 8'h00
`define RGC_CODE_S2 8'h01
`define RGC_CODE_S3 8'h02
`define RGC_CODE_S4 8'h0a
`define RGC_CODE_S5 8'h12
`define RGC_CODE_S6 8'h16

`endif

// File: rtl/rgc_pkg.sv
/*
 Types of the receiver gain control block: lock modes, gain levels, the
 applied gain carrier and the strength measurement states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package rgc_pkg;

   typedef enum logic [1:0] {
      RGC_LOCK_FREE = 2'h0,
      RGC_LOCK_MANUAL = 2'h1,
      RGC_LOCK_HOLD = 2'h2,
      RGC_LOCK_PREAMBLE = 2'h3
   } rgc_lock_mode_t;

   typedef enum logic [1:0] {
      RGC_LVL_HIGH = 2'h0,
      RGC_LVL_MEDIUM = 2'h1,
      RGC_LVL_LOW = 2'h2
   } rgc_level_t;

   typedef struct packed {
      rgc_level_t filter;
      logic mixer_low;
      rgc_level_t lna;
   } rgc_gain_t;

   typedef enum logic [1:0] {
      RGC_MEAS_IDLE = 2'b01,
      RGC_MEAS_AVG = 2'b10
   } rgc_meas_t;

endpackage : rgc_pkg

// File: rtl/rgc_top.sv
/*
 Receiver gain control, signal-strength converter and readback, and the
 correlator frequency demodulator, with a plain register port.
 Assumes all inputs synchronous to core_clk_i; the comparator answers the
 current trial code within the same cycle.
*/
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "rgc_defs.svh"

module rgc_top #(
   parameter int unsigned AVG_LOG2 = 3
) (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic [9:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic rx_active_i,
   input wire logic idle_on_i,
   input wire logic packet_mode_i,
   input wire logic preamble_det_i,
   input wire logic postamble_i,
   input wire logic packet_ok_i,
   input wire logic get_strength_cmd_i,
   input wire logic sar_cmp_i,
   output logic [7:0] sar_trial_o,
   input wire logic if_valid_i,
   input wire logic [7:0] if_i_i,
   input wire logic [7:0] if_q_i,
   output rgc_pkg::rgc_gain_t gain_o,
   output logic demod_bit_o,
   output logic demod_valid_o,
   output logic strength_busy_o
);

   localparam int unsigned DWELL_CYCLES =
      `RGC_DWELL_TIME_NS / `RGC_CLK_PERIOD_NS;
   localparam int unsigned PRESCALE = DWELL_CYCLES / `RGC_DWELL_DIV_DEFAULT;
   localparam logic [7:0] PRE_LAST = 8'(PRESCALE - 1);
   localparam int unsigned ACC_W = 8 + AVG_LOG2;
   localparam logic [AVG_LOG2-1:0] AVG_LAST = '1;

   logic [7:0] disc_bw_reg, disc_phase_reg, lock_cfg_reg, demod_cfg_reg;
   logic [7:0] dwell_div_reg, override_reg, raise_th_reg, cut_th_reg;
   logic [7:0] strength_reg, conv_reg, status_reg, post_level_reg;
   logic [7:0] sar_ptr_reg, sar_kept;
   logic conv_valid_reg;
   logic [7:0] pre_cnt_reg, dwell_cnt_reg, div_eff;
   logic pre_tick, dwell_tick, locked_reg, adjust_en;
   logic [2:0] stage_reg;
   rgc_pkg::rgc_lock_mode_t lock_mode;
   rgc_pkg::rgc_meas_t meas_reg;
   logic [ACC_W-1:0] acc_reg, acc_next;
   logic [AVG_LOG2-1:0] avg_cnt_reg;
   logic [3:0] i_hist_reg, q_hist_reg;
   logic [7:0] win_cnt_reg, win_len;
   logic [8:0] cnt_a_reg, cnt_b_reg, cnt_a_next, cnt_b_next;
   logic i_now, q_now, i_del, q_del, pos_hit, neg_hit, demod_en;

   assign lock_mode = rgc_pkg::rgc_lock_mode_t'(lock_cfg_reg[1:0]);
   assign demod_en = demod_cfg_reg[1:0] == `RGC_DEMOD_CORRELATOR;

   function automatic rgc_pkg::rgc_gain_t stage_gain(input logic [2:0] s);
      rgc_pkg::rgc_gain_t g;
      g.lna = rgc_pkg::RGC_LVL_LOW;
      g.mixer_low = 1'b1;
      g.filter = rgc_pkg::RGC_LVL_HIGH;
      case (s)
         3'h1: begin
            g.lna = rgc_pkg::RGC_LVL_HIGH;
            g.mixer_low = 1'b0;
         end
         3'h2: g.lna = rgc_pkg::RGC_LVL_HIGH;
         3'h3: g.lna = rgc_pkg::RGC_LVL_MEDIUM;
         3'h4: g.filter = rgc_pkg::RGC_LVL_HIGH;
         3'h5: g.filter = rgc_pkg::RGC_LVL_MEDIUM;
         default: g.filter = rgc_pkg::RGC_LVL_LOW;
      endcase
      return g;
   endfunction : stage_gain

   function automatic logic [7:0] stage_code(input logic [2:0] s);
      case (s)
         3'h1: stage_code = `RGC_CODE_S1;
         3'h2: stage_code = `RGC_CODE_S2;
         3'h3: stage_code = `RGC_CODE_S3;
         3'h4: stage_code = `RGC_CODE_S4;
         3'h5: stage_code = `RGC_CODE_S5;
         default: stage_code = `RGC_CODE_S6;
      endcase
   endfunction : stage_code

   // Software-written configuration
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         disc_bw_reg <= `RGC_RST_DISC_BW;
         disc_phase_reg <= `RGC_RST_ZERO;
         lock_cfg_reg <= `RGC_RST_ZERO;
         demod_cfg_reg <= `RGC_RST_ZERO;
         dwell_div_reg <= `RGC_RST_DWELL_DIV;
         override_reg <= `RGC_RST_ZERO;
         raise_th_reg <= `RGC_RST_RAISE_TH;
         cut_th_reg <= `RGC_RST_CUT_TH;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `RGC_OFF_DISC_BW: disc_bw_reg <= reg_wdata_i;
            `RGC_OFF_DISC_PHASE: disc_phase_reg <= reg_wdata_i;
            `RGC_OFF_LOCK_CFG: lock_cfg_reg <= reg_wdata_i;
            `RGC_OFF_DEMOD_CFG: demod_cfg_reg <= reg_wdata_i;
            `RGC_OFF_DWELL_DIV: dwell_div_reg <= reg_wdata_i;
            `RGC_OFF_OVERRIDE: override_reg <= reg_wdata_i;
            `RGC_OFF_RAISE_TH: raise_th_reg <= reg_wdata_i;
            `RGC_OFF_CUT_TH: cut_th_reg <= reg_wdata_i;
            default: ;
         endcase
      end
   end

   // Readback, one cycle after the read strobe
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `RGC_OFF_DISC_BW: reg_rdata_o <= disc_bw_reg;
            `RGC_OFF_DISC_PHASE: reg_rdata_o <= disc_phase_reg;
            `RGC_OFF_LOCK_CFG: reg_rdata_o <= lock_cfg_reg;
            `RGC_OFF_DEMOD_CFG: reg_rdata_o <= demod_cfg_reg;
            `RGC_OFF_STRENGTH: reg_rdata_o <= strength_reg;
            `RGC_OFF_CONV_LO: reg_rdata_o <= conv_reg;
            `RGC_OFF_CONV_HI: reg_rdata_o <= 8'h00;
            `RGC_OFF_DWELL_DIV: reg_rdata_o <= dwell_div_reg;
            `RGC_OFF_OVERRIDE: reg_rdata_o <= override_reg;
            `RGC_OFF_RAISE_TH: reg_rdata_o <= raise_th_reg;
            `RGC_OFF_CUT_TH: reg_rdata_o <= cut_th_reg;
            `RGC_OFF_GAIN_STATE: reg_rdata_o <= status_reg;
            `RGC_OFF_CONV_WORD: reg_rdata_o <= {1'b0, conv_reg[7:1]};
            default: reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   // Successive approximation, MSB first, restarts after each result
   assign sar_kept = sar_cmp_i ? sar_trial_o : (sar_trial_o & ~sar_ptr_reg);
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sar_ptr_reg <= 8'h80;
         sar_trial_o <= 8'h80;
         conv_reg <= 8'h00;
         conv_valid_reg <= 1'b0;
      end else if (sar_ptr_reg[0]) begin
         conv_reg <= sar_kept;
         conv_valid_reg <= 1'b1;
         sar_ptr_reg <= 8'h80;
         sar_trial_o <= 8'h80;
      end else begin
         conv_valid_reg <= 1'b0;
         sar_ptr_reg <= sar_ptr_reg >> 1;
         sar_trial_o <= sar_kept | (sar_ptr_reg >> 1);
      end
   end

   // Dwell timing: fixed prescaler times the programmed divider
   assign div_eff = (dwell_div_reg == 8'h00) ? 8'h01 : dwell_div_reg;
   assign pre_tick = pre_cnt_reg == PRE_LAST;
   assign dwell_tick = pre_tick && (dwell_cnt_reg >= div_eff - 8'h01);
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pre_cnt_reg <= 8'h00;
         dwell_cnt_reg <= 8'h00;
      end else begin
         pre_cnt_reg <= pre_tick ? 8'h00 : pre_cnt_reg + 8'h01;
         if (dwell_tick) begin
            dwell_cnt_reg <= 8'h00;
         end else if (pre_tick) begin
            dwell_cnt_reg <= dwell_cnt_reg + 8'h01;
         end
      end
   end

   // Preamble lock, released when receive ends
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         locked_reg <= 1'b0;
      end else if (rx_active_i && preamble_det_i &&
                   lock_mode == rgc_pkg::RGC_LOCK_PREAMBLE) begin
         locked_reg <= 1'b1;
      end else if (!rx_active_i) begin
         locked_reg <= 1'b0;
      end
   end

   assign adjust_en = rx_active_i && !override_reg[`RGC_OVR_HOLD_BIT] &&
      (lock_mode == rgc_pkg::RGC_LOCK_FREE ||
       (lock_mode == rgc_pkg::RGC_LOCK_PREAMBLE && !locked_reg));

   // Stage stepping
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stage_reg <= `RGC_STAGE_MIN;
      end else if (dwell_tick && adjust_en) begin
         if (conv_reg > cut_th_reg && stage_reg < `RGC_STAGE_MAX) begin
            stage_reg <= stage_reg + 3'h1;
         end else if (conv_reg < raise_th_reg &&
                      stage_reg > `RGC_STAGE_MIN) begin
            stage_reg <= stage_reg - 3'h1;
         end
      end
   end

   // Applied gains and their status code
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gain_o <= stage_gain(`RGC_STAGE_MIN);
         status_reg <= `RGC_CODE_S1;
      end else if (lock_mode == rgc_pkg::RGC_LOCK_MANUAL) begin
         gain_o <= rgc_pkg::rgc_gain_t'(override_reg[4:0]);
         status_reg <= {3'h0, override_reg[4:0]};
      end else begin
         gain_o <= stage_gain(stage_reg);
         status_reg <= stage_code(stage_reg);
      end
   end

   // Strength captures: postamble level and filtered get-strength
   assign acc_next = acc_reg + ACC_W'(conv_reg);
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         post_level_reg <= 8'h00;
      end else if (postamble_i && conv_valid_reg) begin
         post_level_reg <= conv_reg;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meas_reg <= rgc_pkg::RGC_MEAS_IDLE;
         acc_reg <= '0;
         avg_cnt_reg <= '0;
         strength_reg <= 8'h00;
         strength_busy_o <= 1'b0;
      end else begin
         case (meas_reg)
            rgc_pkg::RGC_MEAS_IDLE: begin
               if (packet_ok_i && packet_mode_i && demod_en) begin
                  strength_reg <= post_level_reg;
               end
               if (get_strength_cmd_i && idle_on_i) begin
                  meas_reg <= rgc_pkg::RGC_MEAS_AVG;
                  acc_reg <= '0;
                  avg_cnt_reg <= '0;
                  strength_busy_o <= 1'b1;
               end
            end
            rgc_pkg::RGC_MEAS_AVG: begin
               if (conv_valid_reg) begin
                  acc_reg <= acc_next;
                  avg_cnt_reg <= avg_cnt_reg + AVG_LOG2'(1);
                  if (avg_cnt_reg == AVG_LAST) begin
                     strength_reg <= acc_next[ACC_W-1:AVG_LOG2];
                     meas_reg <= rgc_pkg::RGC_MEAS_IDLE;
                     strength_busy_o <= 1'b0;
                  end
               end
            end
            default: begin
               meas_reg <= rgc_pkg::RGC_MEAS_IDLE;
               strength_busy_o <= 1'b0;
            end
         endcase
      end
   end

   // Correlator demodulator on hard-limited IQ
   assign i_now = if_i_i[7];
   assign q_now = if_q_i[7];
   assign i_del = i_hist_reg[disc_phase_reg[1:0]];
   assign q_del = q_hist_reg[disc_phase_reg[1:0]];
   assign pos_hit = (i_now == q_del) && (q_now != i_del);
   assign neg_hit = (i_now != q_del) && (q_now == i_del);
   assign cnt_a_next = cnt_a_reg + {8'h00, pos_hit};
   assign cnt_b_next = cnt_b_reg + {8'h00, neg_hit};
   assign win_len = (disc_bw_reg == 8'h00) ? 8'h01 : disc_bw_reg;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         i_hist_reg <= 4'h0;
         q_hist_reg <= 4'h0;
         win_cnt_reg <= 8'h00;
         cnt_a_reg <= 9'h000;
         cnt_b_reg <= 9'h000;
         demod_bit_o <= 1'b0;
         demod_valid_o <= 1'b0;
      end else if (!demod_en) begin
         win_cnt_reg <= 8'h00;
         cnt_a_reg <= 9'h000;
         cnt_b_reg <= 9'h000;
         demod_valid_o <= 1'b0;
      end else if (if_valid_i) begin
         i_hist_reg <= {i_hist_reg[2:0], i_now};
         q_hist_reg <= {q_hist_reg[2:0], q_now};
         if (win_cnt_reg >= win_len - 8'h01) begin
            demod_bit_o <= cnt_a_next > cnt_b_next;
            demod_valid_o <= 1'b1;
            win_cnt_reg <= 8'h00;
            cnt_a_reg <= 9'h000;
            cnt_b_reg <= 9'h000;
         end else begin
            demod_valid_o <= 1'b0;
            win_cnt_reg <= win_cnt_reg + 8'h01;
            cnt_a_reg <= cnt_a_next;
            cnt_b_reg <= cnt_b_next;
         end
      end else begin
         demod_valid_o <= 1'b0;
      end
   end

   // Checks
   a_stage_bounds: assert property (@(posedge core_clk_i)
      disable iff (!arst_n_i)
      stage_reg >= `RGC_STAGE_MIN && stage_reg <= `RGC_STAGE_MAX)
      else $error("gain stage out of range");

   a_step_per_dwell: assert property (@(posedge core_clk_i)
      disable iff (!arst_n_i)
      !dwell_tick |=> $stable(stage_reg))
      else $error("stage moved without a dwell tick");

   a_cut_lowers: assert property (@(posedge core_clk_i)
      disable iff (!arst_n_i)
      dwell_tick && adjust_en && conv_reg > cut_th_reg &&
      stage_reg < `RGC_STAGE_MAX |=> stage_reg == $past(stage_reg) + 3'h1)
      else $error("strong signal did not cut gain");

   a_raise_gain: assert property (@(posedge core_clk_i)
      disable iff (!arst_n_i)
      dwell_tick && adjust_en && conv_reg <= cut_th_reg &&
      conv_reg < raise_th_reg && stage_reg > `RGC_STAGE_MIN
      |=> stage_reg == $past(stage_reg) - 3'h1)
      else $error("weak signal did not raise gain");

   a_hold_mode: assert property (@(posedge core_clk_i)
      disable iff (!arst_n_i)
      lock_mode == rgc_pkg::RGC_LOCK_HOLD |=> $stable(stage_reg))
      else $error("stage changed in hold mode");

   a_manual_apply: assert property (@(posedge core_clk_i)
      disable iff (!arst_n_i)
      lock_mode == rgc_pkg::RGC_LOCK_MANUAL
      |=> gain_o == rgc_pkg::rgc_gain_t'($past(override_reg[4:0])))
      else $error("manual gains not applied");

   a_status_match: assert property (@(posedge core_clk_i)
      disable iff (!arst_n_i)
      lock_mode != rgc_pkg::RGC_LOCK_MANUAL ##1
      $stable(stage_reg) && lock_mode != rgc_pkg::RGC_LOCK_MANUAL
      |-> status_reg == stage_code(stage_reg) &&
      gain_o == stage_gain(stage_reg))
      else $error("status disagrees with applied stage");

   a_sar_period: assert property (@(posedge core_clk_i)
      disable iff (!arst_n_i)
      conv_valid_reg |=> !conv_valid_reg [*7] ##1 conv_valid_reg)
      else $error("conversion not every eight cycles");

   a_packet_capture: assert property (@(posedge core_clk_i)
      disable iff (!arst_n_i)
      meas_reg == rgc_pkg::RGC_MEAS_IDLE && packet_ok_i &&
      (!packet_mode_i || !demod_en) |=> $stable(strength_reg))
      else $error("strength captured outside packet FSK");

   a_demod_off: assert property (@(posedge core_clk_i)
      disable iff (!arst_n_i)
      !demod_en |=> !demod_valid_o)
      else $error("demodulator output while not selected");

endmodule : rgc_top

`default_nettype wire

// File: verification/rgc_afe_model.sv
/*
 Analog front-end stand-in: the strength comparator seen by the converter.
 Assumes the level is set by the bench and the trial code comes from rgc_top.
*/
`timescale 1ns/1ns
`default_nettype none
module rgc_afe_model (
   input wire logic [7:0] trial_i,
   input wire logic [7:0] level_i,
   output logic cmp_o
);
   // Answers within the cycle, as the converter expects
   assign cmp_o = (level_i >= trial_i);
endmodule : rgc_afe_model
`default_nettype wire

// File: verification/testbench.sv
/*
 Self-checking bench of rgc_top: register table, converter, gain stepping,
 lock modes, strength capture and demodulator strobes.
 Assumes rgc_afe_model as the analog front end.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rgc_defs.svh"
module testbench;
   typedef struct packed {
      logic [9:0] a;
      logic [7:0] d;
      logic w;
      logic [7:0] e;
   } rgc_tbrow_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [9:0] addr = 10'h000;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0, rd = 1'b0, rx = 1'b0, idle_on = 1'b0, pkt_mode = 1'b0;
   logic pre_det = 1'b0, post = 1'b0, pkt_ok = 1'b0, get_cmd = 1'b0;
   logic iq_vld = 1'b0;
   logic [7:0] level = 8'h40;
   logic [7:0] iq = 8'h00;
   logic [7:0] rdata, trial, v;
   logic cmp, dbit, dvalid, busy;
   rgc_pkg::rgc_gain_t gain;
   int n_mismatch = 0, total_checks = 0, cyc = 0, last = 0, n;
   logic [4:0] eg [6] = '{5'h00, 5'h04, 5'h05, 5'h06, 5'h0e, 5'h16};
   logic [7:0] es [6] = '{`RGC_CODE_S1, `RGC_CODE_S2, `RGC_CODE_S3,
                          `RGC_CODE_S4, `RGC_CODE_S5, `RGC_CODE_S6};
   rgc_tbrow_t rows [16] = '{
      '{10'h32f, 8'h00, 1'b0, 8'h28}, '{10'h35e, 8'h00, 1'b0, 8'h20},
      '{10'h35f, 8'h00, 1'b0, 8'h60}, '{10'h10f, 8'h00, 1'b0, 8'h10},
      '{10'h113, 8'h00, 1'b0, 8'h00}, '{10'h360, 8'h00, 1'b0, 8'h00},
      '{10'h35e, 8'h30, 1'b1, 8'h00}, '{10'h35e, 8'h00, 1'b0, 8'h30},
      '{10'h35f, 8'h70, 1'b1, 8'h00}, '{10'h35f, 8'h00, 1'b0, 8'h70},
      '{10'h112, 8'h03, 1'b1, 8'h00}, '{10'h112, 8'h00, 1'b0, 8'h03},
      '{10'h360, 8'h55, 1'b1, 8'h00}, '{10'h360, 8'h00, 1'b0, 8'h00},
      '{10'h001, 8'h5a, 1'b1, 8'h00}, '{10'h001, 8'h00, 1'b0, 8'h00}};

   always #5 clk = ~clk;

   rgc_top dut_u (.core_clk_i(clk), .arst_n_i(rst_n), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .rx_active_i(rx), .idle_on_i(idle_on), .packet_mode_i(pkt_mode),
      .preamble_det_i(pre_det), .postamble_i(post), .packet_ok_i(pkt_ok),
      .get_strength_cmd_i(get_cmd), .sar_cmp_i(cmp), .sar_trial_o(trial),
      .if_valid_i(iq_vld), .if_i_i(iq), .if_q_i(~iq), .gain_o(gain),
      .demod_bit_o(dbit), .demod_valid_o(dvalid), .strength_busy_o(busy));
   rgc_afe_model afe_u (.trial_i(trial), .level_i(level), .cmp_o(cmp));

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic step_chk(input int s, input bit timed);
      logic [4:0] g;
      g = gain;
      n = 0;
      while (gain === g && n < 3000) begin
         @(posedge clk);
         n++;
      end
      #1;
      if (timed) chk(8'(cyc - last), 8'd62);
      last = cyc;
      chk({3'h0, gain}, {3'h0, eg[s]});
      rd_reg(`RGC_OFF_GAIN_STATE, v);
      chk(v, es[s]);
   endtask : step_chk

   task automatic hold_chk();
      logic [4:0] g;
      repeat (4) @(posedge clk);
      g = gain;
      repeat (200) @(posedge clk);
      chk({3'h0, gain}, {3'h0, g});
   endtask : hold_chk

   task automatic pkt(input logic m, input logic [7:0] lv);
      pkt_mode <= m;
      level <= lv;
      post <= 1'b1;
      repeat (20) @(posedge clk);
      post <= 1'b0;
      pkt_ok <= 1'b1;
      @(posedge clk);
      pkt_ok <= 1'b0;
      repeat (2) @(posedge clk);
      rd_reg(`RGC_OFF_STRENGTH, v);
   endtask : pkt

   task automatic iq_chk(input logic [7:0] s, input logic e);
      @(posedge clk);
      iq <= s;
      iq_vld <= 1'b1;
      @(posedge clk);
      iq_vld <= 1'b0;
      #1 chk({7'h0, dvalid}, {7'h0, e});
   endtask : iq_chk

   initial begin
      repeat (12) @(posedge clk);
      chk({3'h0, gain}, 8'h00);
      chk(trial, 8'h80);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].w) begin
            wr_reg(rows[i].a, rows[i].d);
         end else begin
            rd_reg(rows[i].a, v);
            chk(v, rows[i].e);
         end
      end
      wr_reg(`RGC_OFF_DWELL_DIV, 8'h01);
      level <= 8'h55;
      repeat (20) @(posedge clk);
      rd_reg(`RGC_OFF_CONV_LO, v);
      chk(v, 8'h55);
      rd_reg(`RGC_OFF_CONV_HI, v);
      chk(v, 8'h00);
      rd_reg(`RGC_OFF_CONV_WORD, v);
      chk(v, 8'h2a);
      idle_on <= 1'b1;
      get_cmd <= 1'b1;
      @(posedge clk);
      get_cmd <= 1'b0;
      #1 chk({7'h0, busy}, 8'h01);
      n = 0;
      while (busy !== 1'b0 && n < 300) begin
         @(posedge clk);
         n++;
      end
      idle_on <= 1'b0;
      rd_reg(`RGC_OFF_STRENGTH, v);
      chk(v, 8'h55);
      pkt(1'b1, 8'h33);
      chk(v, 8'h33);
      pkt(1'b0, 8'h44);
      chk(v, 8'h33);
      wr_reg(`RGC_OFF_DISC_BW, 8'h01);
      iq_chk(8'h10, 1'b1);
      chk({7'h0, dbit}, 8'h01);
      wr_reg(`RGC_OFF_DISC_BW, 8'h02);
      iq_chk(8'h90, 1'b0);
      iq_chk(8'h10, 1'b1);
      wr_reg(`RGC_OFF_DEMOD_CFG, 8'h01);
      iq_chk(8'h10, 1'b0);
      wr_reg(`RGC_OFF_DEMOD_CFG, 8'h00);
      level <= 8'h80;
      rx <= 1'b1;
      for (int s = 1; s < 6; s++) step_chk(s, s > 1);
      hold_chk();
      level <= 8'h10;
      for (int s = 4; s >= 0; s--) step_chk(s, s < 4);
      hold_chk();
      wr_reg(`RGC_OFF_LOCK_CFG, 8'h02);
      level <= 8'h80;
      hold_chk();
      level <= 8'h10;
      wr_reg(`RGC_OFF_LOCK_CFG, 8'h00);
      wr_reg(`RGC_OFF_OVERRIDE, 8'h40);
      level <= 8'h80;
      hold_chk();
      wr_reg(`RGC_OFF_LOCK_CFG, 8'h03);
      pre_det <= 1'b1;
      @(posedge clk);
      pre_det <= 1'b0;
      wr_reg(`RGC_OFF_OVERRIDE, 8'h00);
      hold_chk();
      wr_reg(`RGC_OFF_LOCK_CFG, 8'h00);
      step_chk(1, 1'b0);
      wr_reg(`RGC_OFF_LOCK_CFG, 8'h01);
      wr_reg(`RGC_OFF_OVERRIDE, 8'h12);
      repeat (4) @(posedge clk);
      chk({3'h0, gain}, 8'h12);
      rd_reg(`RGC_OFF_GAIN_STATE, v);
      chk(v, 8'h12);
      hold_chk();
      final_report();
   end
endmodule : testbench
`default_nettype wire
